// *** design/ifv_ctrl.sv ***
// Operation
// - Fourteen sources are accepted, each with its own flag bit.
// - The main control register holds core flags, their enables and the global enable.
// - A flag sets on its event regardless of its enable, the group enable or the global enable.
// - Global enable at bit 7 passes unmasked requests when set and blocks all when clear.
// - With global enable set, a core flag with its enable set, or a peripheral flag with its enable and the group enable set, starts the wait to vector.
// - Every reset clears the global enable.
// - The return-from-handler operation leaves the handler and sets the global enable.
// - External edge, port change and timer zero flags live in the main control register.
// - Peripheral flags sit in two flag registers with two enable registers; group enable is in main control.
// - Taking an interrupt clears global enable, pushes the return address and loads address 0004h.
// - External events reach the vector three or four instruction cycles after they arrive.
// - Latency does not depend on whether the current instruction takes one or two cycles.
// - An instruction cycle is four oscillator periods.
`timescale 1ns/1ps
`default_nettype none
module ifv_ctrl
  import ifv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic external_edge_irq_pin,
  input wire logic port_change_evt,
  input wire logic timer_zero_ovf,
  input wire logic [7:0] periph_evt_a,
  input wire logic [2:0] periph_evt_b,
  input wire logic return_from_handler_op,
  input wire logic [12:0] program_counter,
  output logic vector_load,
  output logic [12:0] vector_addr,
  output logic stack_push,
  output logic [12:0] stack_push_addr,
  output logic core_irq_req,
  output logic irq
);
  ifv_bus_req_t bus;
  ifv_events_t evt;
  logic [1:0] ext_sync;
  logic ext_prev;
  logic ext_rise;
  logic [7:0] main_irq_control_reg;
  logic [7:0] peripheral_flag_reg_a;
  logic [7:0] peripheral_enable_reg_a;
  logic [2:0] peripheral_flag_reg_b;
  logic [2:0] peripheral_enable_reg_b;
  logic [2:0] evt_stat;
  logic [2:0] evt_en;
  logic global_irq_enable;
  logic peripheral_group_enable;
  logic core_hit;
  logic periph_hit;
  logic next_req;
  logic take;
  logic [1:0] phase;
  logic [1:0] wait_icyc;
  ifv_state_t state;
  logic [2:0] evt_pulse;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // Pin passes two flops before the edge detector reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_sync <= 2'b00;
      ext_prev <= 1'b0;
    end else begin
      ext_sync <= {ext_sync[0], external_edge_irq_pin};
      ext_prev <= ext_sync[1];
    end
  end
  assign ext_rise = ext_sync[1] & ~ext_prev;

  assign evt = '{ext_edge: ext_rise, port_change: port_change_evt, timer_zero_ovf: timer_zero_ovf,
                 periph_a: periph_evt_a, periph_b: periph_evt_b};

  assign global_irq_enable = main_irq_control_reg[GIE_BIT];
  assign peripheral_group_enable = main_irq_control_reg[PGE_BIT];
  assign take = (state == ST_VECTOR);

  // Main control: core flags, core enables, group and global enable
  always_ff @(posedge clk) begin
    if (srst) begin
      main_irq_control_reg <= MAIN_CTRL_RST;
    end else begin
      if (bus.wr && bus.addr == OFF_MAIN_CTRL) begin
        main_irq_control_reg <= bus.wdata;
      end
      if (take) begin
        main_irq_control_reg[GIE_BIT] <= 1'b0;
      end else if (return_from_handler_op) begin
        main_irq_control_reg[GIE_BIT] <= 1'b1;
      end
      // Events win over a software write in the same cycle
      if (evt.ext_edge) main_irq_control_reg[EXF_BIT] <= 1'b1;
      if (evt.port_change) main_irq_control_reg[PCF_BIT] <= 1'b1;
      if (evt.timer_zero_ovf) main_irq_control_reg[T0F_BIT] <= 1'b1;
    end
  end

  // Peripheral flag registers; set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      peripheral_flag_reg_a <= REG_RST;
      peripheral_flag_reg_b <= 3'h0;
    end else begin
      peripheral_flag_reg_a <= ((bus.wr && bus.addr == OFF_PFLAG_A) ? bus.wdata : peripheral_flag_reg_a)
                               | evt.periph_a;
      peripheral_flag_reg_b <= ((bus.wr && bus.addr == OFF_PFLAG_B) ? bus.wdata[2:0] : peripheral_flag_reg_b)
                               | evt.periph_b;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      peripheral_enable_reg_a <= REG_RST;
      peripheral_enable_reg_b <= 3'h0;
    end else begin
      if (bus.wr && bus.addr == OFF_PEN_A) peripheral_enable_reg_a <= bus.wdata;
      if (bus.wr && bus.addr == OFF_PEN_B) peripheral_enable_reg_b <= bus.wdata[2:0];
    end
  end

  // Request combine over all fourteen sources
  assign core_hit = (main_irq_control_reg[T0F_BIT] & main_irq_control_reg[T0E_BIT])
                  | (main_irq_control_reg[EXF_BIT] & main_irq_control_reg[EXE_BIT])
                  | (main_irq_control_reg[PCF_BIT] & main_irq_control_reg[PCE_BIT]);
  assign periph_hit = peripheral_group_enable
                    & (|(peripheral_flag_reg_a & peripheral_enable_reg_a)
                       | |(peripheral_flag_reg_b & peripheral_enable_reg_b));
  assign next_req = global_irq_enable & (core_hit | periph_hit);

  // Instruction cycle phase counter, four clocks per cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      phase <= 2'b00;
    end else begin
      phase <= (phase == PHASE_LAST) ? 2'b00 : phase + 2'b01;
    end
  end

  // Vectoring sequencer. Waiting is counted in instruction cycles, the last one cut short at PHASE_EXIT, so the
  // latency is three or four of them no matter which instruction is executing.
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= ST_RUN;
      wait_icyc <= 2'b00;
    end else begin
      case (state)
        ST_RUN: begin
          if (next_req) begin
            state <= ST_WAIT;
            wait_icyc <= 2'b00;
          end
        end
        ST_WAIT: begin
          // The last cycle ends early so that pin to vector stays within four cycles
          if (wait_icyc == LAT_WAIT_ICYC) begin
            if (phase == PHASE_EXIT) begin
              state <= ST_VECTOR;
            end
          end else if (phase == PHASE_LAST) begin
            wait_icyc <= wait_icyc + 2'b01;
          end
        end
        ST_VECTOR: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Vector, push and request outputs, all registered
  always_ff @(posedge clk) begin
    if (srst) begin
      vector_load <= 1'b0;
      vector_addr <= 13'h0000;
      stack_push <= 1'b0;
      stack_push_addr <= 13'h0000;
      core_irq_req <= 1'b0;
    end else begin
      vector_load <= take;
      stack_push <= take;
      vector_addr <= VECTOR_ADDR;
      if (take) stack_push_addr <= program_counter;
      core_irq_req <= next_req;
    end
  end

  // Sequencer event status, enable and level interrupt
  assign evt_pulse = {next_req & ~core_irq_req, return_from_handler_op, take};

  always_ff @(posedge clk) begin
    if (srst) begin
      evt_stat <= EV_RST;
      evt_en <= EV_RST;
      irq <= 1'b0;
    end else begin
      // Clear first, then set, so a coincident event survives
      evt_stat <= (evt_stat & ~((bus.wr && bus.addr == OFF_EVT_CLR) ? bus.wdata[2:0] : 3'h0)) | evt_pulse;
      if (bus.wr && bus.addr == OFF_EVT_EN) evt_en <= bus.wdata[2:0];
      irq <= |(evt_stat & evt_en);
    end
  end

  // Read port: data in the cycle after the strobe only
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        OFF_MAIN_CTRL: rdata <= main_irq_control_reg;
        OFF_PFLAG_A: rdata <= peripheral_flag_reg_a;
        OFF_PFLAG_B: rdata <= {5'h00, peripheral_flag_reg_b};
        OFF_PEN_A: rdata <= peripheral_enable_reg_a;
        OFF_PEN_B: rdata <= {5'h00, peripheral_enable_reg_b};
        OFF_CORE_STAT: rdata <= {5'h00, state};
        OFF_EVT_STAT: rdata <= {5'h00, evt_stat};
        OFF_EVT_EN: rdata <= {5'h00, evt_en};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : ifv_ctrl
`default_nettype wire

// *** design/ifv_pkg.sv ***
package ifv_pkg;
  // Register offsets on the plain register port
  localparam logic [3:0] OFF_MAIN_CTRL = 4'h0;
  localparam logic [3:0] OFF_PFLAG_A = 4'h1;
  localparam logic [3:0] OFF_PFLAG_B = 4'h2;
  localparam logic [3:0] OFF_PEN_A = 4'h3;
  localparam logic [3:0] OFF_PEN_B = 4'h4;
  localparam logic [3:0] OFF_CORE_STAT = 4'h5;
  localparam logic [3:0] OFF_EVT_STAT = 4'h6;
  localparam logic [3:0] OFF_EVT_CLR = 4'h7;
  localparam logic [3:0] OFF_EVT_EN = 4'h8;
  // Main control register fields
  localparam int GIE_BIT = 7;
  localparam int PGE_BIT = 6;
  localparam int T0E_BIT = 5;
  localparam int EXE_BIT = 4;
  localparam int PCE_BIT = 3;
  localparam int T0F_BIT = 2;
  localparam int EXF_BIT = 1;
  localparam int PCF_BIT = 0;
  localparam int NUM_SOURCES = 14;
  localparam int NUM_PERIPH_A = 8;
  localparam int NUM_PERIPH_B = 3;
  localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [12:0] VECTOR_ADDR = 13'h0004;
  // Latency: 4 oscillator periods per instruction cycle
  localparam int OSC_PER_ICYC = 4;
  localparam int LAT_MIN_ICYC = 3;
  localparam int LAT_MIN_CLK = LAT_MIN_ICYC * OSC_PER_ICYC;
  localparam logic [1:0] PHASE_LAST = 2'(OSC_PER_ICYC - 1);
  localparam logic [1:0] LAT_WAIT_ICYC = 2'(LAT_MIN_ICYC - 1);
  // Phase at which the last wait cycle ends; makes up for the pin sync and flag stage
  localparam logic [1:0] PHASE_EXIT = 2'(OSC_PER_ICYC - 3);
  // Event status bits
  localparam int EV_TAKEN = 0;
  localparam int EV_RETURN = 1;
  localparam int EV_PENDING = 2;
  localparam logic [2:0] EV_RST = 3'h0;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ifv_bus_req_t;

  typedef struct packed {
    logic ext_edge;
    logic port_change;
    logic timer_zero_ovf;
    logic [NUM_PERIPH_A-1:0] periph_a;
    logic [NUM_PERIPH_B-1:0] periph_b;
  } ifv_events_t;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WAIT = 3'b010,
    ST_VECTOR = 3'b100
  } ifv_state_t;
endpackage : ifv_pkg

// *** tb/ifv_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifv_core_model
  import ifv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ret_req,
  input wire logic vector_load,
  input wire logic [12:0] vector_addr,
  input wire logic stack_push,
  input wire logic [12:0] stack_push_addr,
  output logic return_from_handler_op,
  output logic [12:0] program_counter
);
  logic [12:0] stack_top;
  // PC stands still between jumps so the pushed address is predictable
  always_ff @(posedge clk) begin
    if (srst) begin
      program_counter <= 13'h0100;
      return_from_handler_op <= 1'b0;
      stack_top <= 13'h0000;
    end else begin
      return_from_handler_op <= ret_req;
      if (vector_load) program_counter <= vector_addr;
      else if (return_from_handler_op) program_counter <= stack_top;
      if (stack_push) stack_top <= stack_push_addr;
    end
  end
endmodule : ifv_core_model
`default_nettype wire

// *** tb/ifv_ctrl_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ifv_ctrl_chk
  import ifv_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic vector_load,
  input wire logic [12:0] vector_addr,
  input wire logic stack_push,
  input wire logic core_irq_req,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_req_rise;
    $rose(core_irq_req);
  endsequence
  sequence s_take_due;
    ##[8:14] vector_load;
  endsequence
  a_take_latency: assert property (s_req_rise |-> s_take_due) else $error("take late");
  a_push_pair: assert property (stack_push == vector_load) else $error("push apart from load");
  a_vector_fixed: assert property (!$past(srst) |-> vector_addr == VECTOR_ADDR) else $error("bad vector");
  a_req_lead: assert property (vector_load |-> $past(core_irq_req)) else $error("take without req");
  a_load_spacing: assert property (vector_load |=> !vector_load [*8]) else $error("second take");
  a_take_clears: assert property (vector_load |=> !core_irq_req) else $error("global kept");
  a_reset_quiet: assert property (disable iff (1'b0) srst |=> !vector_load && !core_irq_req && !irq)
    else $error("active in reset");
  a_no_req_rst: assert property ($fell(srst) |-> !core_irq_req [*2]) else $error("req after reset");
endmodule : ifv_ctrl_chk
bind ifv_ctrl ifv_ctrl_chk i_ifv_ctrl_chk (.*);
`default_nettype wire

// *** tb/tb_ifv_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_ifv_ctrl
  import ifv_pkg::*;
;
  logic clk, srst, wr, rd, ext, pchg, t0, ret_req, vload, push, req, irq, rfh;
  logic [3:0] addr;
  logic [7:0] wdata, pa, rdata;
  logic [2:0] pb;
  logic [12:0] pc, vaddr, paddr;
  int num_errors = 0, n_compared = 0, n_takes = 0, k;
  ifv_ctrl i_ifv_ctrl (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .external_edge_irq_pin(ext), .port_change_evt(pchg), .timer_zero_ovf(t0), .periph_evt_a(pa),
    .periph_evt_b(pb), .return_from_handler_op(rfh), .program_counter(pc), .vector_load(vload),
    .vector_addr(vaddr), .stack_push(push), .stack_push_addr(paddr), .core_irq_req(req), .irq(irq));
  ifv_core_model i_ifv_core_model (.clk(clk), .srst(srst), .ret_req(ret_req), .vector_load(vload),
    .vector_addr(vaddr), .stack_push(push), .stack_push_addr(paddr), .return_from_handler_op(rfh),
    .program_counter(pc));
  always @(posedge clk) if (vload === 1'b1) n_takes++;
  task automatic cmp(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp({5'h00, rdata}, {5'h00, e});
  endtask : rd_chk
  task automatic pulse(input logic [13:0] ev);
    @(posedge clk);
    {ext, pchg, t0, pa, pb} <= ev;
    @(posedge clk);
    {ext, pchg, t0, pa, pb} <= 14'h0000;
  endtask : pulse
  task automatic wait_take(input int lim);
    #1;
    k = 0;
    while (vload !== 1'b1 && k < lim) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask : wait_take
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    cmp({12'h000, irq}, {12'h000, e});
  endtask : chk_irq
  task automatic t_flags;
    pulse(14'h0800);
    rd_chk(OFF_MAIN_CTRL, 8'h04);
    pulse(14'h1000);
    pulse(14'h2000);
    repeat (3) @(posedge clk);
    rd_chk(OFF_MAIN_CTRL, 8'h07);
    pulse(14'h07FF);
    rd_chk(OFF_PFLAG_A, 8'hFF);
    rd_chk(OFF_PFLAG_B, 8'h07);
    wr_reg(OFF_PEN_B, 8'h07);
    rd_chk(OFF_PEN_B, 8'h07);
    wr_reg(OFF_MAIN_CTRL, 8'h00);
    wr_reg(OFF_PFLAG_A, 8'h00);
    rd_chk(OFF_MAIN_CTRL, 8'h00);
    rd_chk(4'hF, 8'h00);
  endtask : t_flags
  task automatic t_take;
    wr_reg(OFF_EVT_EN, 8'h01);
    wr_reg(OFF_MAIN_CTRL, 8'h90);
    @(posedge clk);
    ext <= 1'b1;
    wait_take(30);
    cmp(13'(k >= 12 && k <= 16), 13'h0001);
    cmp(vaddr, VECTOR_ADDR);
    cmp(paddr, 13'h0100);
    ext <= 1'b0;
    rd_chk(OFF_MAIN_CTRL, 8'h12);
    chk_irq(1'b1);
    wr_reg(OFF_EVT_EN, 8'h00);
    chk_irq(1'b0);
    wr_reg(OFF_EVT_CLR, 8'h07);
    wr_reg(OFF_EVT_EN, 8'h01);
    chk_irq(1'b0);
    // Handler clears its flag first, else the return would re-enter at once
    wr_reg(OFF_MAIN_CTRL, 8'h10);
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    rd_chk(OFF_MAIN_CTRL, 8'h90);
    k = n_takes;
    repeat (20) @(posedge clk);
    cmp(13'(n_takes), 13'(k));
  endtask : t_take
  task automatic t_gate;
    wr_reg(OFF_PEN_A, 8'h01);
    wr_reg(OFF_MAIN_CTRL, 8'h20);
    pulse(14'h0800);
    wait_take(20);
    cmp(13'(k), 13'h0014);
    wr_reg(OFF_MAIN_CTRL, 8'h80);
    pulse(14'h0008);
    wait_take(20);
    cmp(13'(k), 13'h0014);
    wr_reg(OFF_MAIN_CTRL, 8'hC0);
    wait_take(20);
    cmp(13'(k < 20), 13'h0001);
  endtask : t_gate
  task automatic finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {srst, wr, rd, ext, pchg, t0, ret_req} = 7'h40;
    {addr, wdata, pa, pb} = 23'h00_0000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd_chk(OFF_MAIN_CTRL, 8'h00);
    t_flags;
    t_take;
    t_gate;
    finish_test;
  end
  initial begin
    #100000;
    num_errors++;
    finish_test;
  end
endmodule : tb_ifv_ctrl
`default_nettype wire
